// *** addr_step.sv ***
// Address update unit for one side of the channel.
module addr_step
   import dma_chan_pkg::*;
#(
   parameter int AW = ADDR_W
) (
   input  wire logic [AW-1:0] addr_in,
   input  wire logic [1:0]    mode_in,
   input  wire logic [1:0]    size_in,
   output logic [AW-1:0]      addr_out
);
   initial begin
      if (AW < 8) $error("addr_step: address width too small");
   end

   // *************************************************************
   // Step computation
   // *************************************************************
   // Only byte units are built, so the step is one; other sizes fall back to byte.
   always_comb begin
      addr_out = addr_in;
      if (mode_in == ADDR_INCREMENT) begin
         addr_out = addr_in + AW'(size_in == SIZE_BYTE ? 1 : 1); // RULE_08
      end
   end
endmodule

// *** dma_bus_slave.sv ***
// Partner model of the on-chip bus slaves that answer the channel's bus cycles.
module dma_bus_slave (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic [3:0]  wait_in,
   input  wire logic        bus_req_in,
   input  wire logic        bus_we_in,
   output logic             bus_ready_out,
   output logic [7:0]       bus_rdata_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************************************
   // Wait states and answers
   // ***************************************************************
   logic [3:0] wait_cnt;
   logic [7:0] read_cnt;

   // Ready is a one-cycle answer after wait_in idle cycles, so slow slaves can be mimicked.
   // Read data is valid only in the ready cycle; otherwise it toggles so stale bytes never pass.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         bus_ready_out <= 1'b0;
         wait_cnt      <= 4'h0;
         read_cnt      <= 8'h00;
         bus_rdata_out <= 8'h5A;
      end else if (bus_ready_out) begin
         bus_ready_out <= 1'b0;
         wait_cnt      <= 4'h0;
         bus_rdata_out <= ~bus_rdata_out;
         if (!bus_we_in) begin
            read_cnt <= read_cnt + 8'h01;
         end
      end else if (bus_req_in && wait_cnt >= wait_in) begin
         bus_ready_out <= 1'b1;
         bus_rdata_out <= 8'h40 + read_cnt;
      end else begin
         bus_rdata_out <= ~bus_rdata_out;
         if (bus_req_in) begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule

// *** dma_chan_pkg.sv ***
// Package of constants and types for the peripheral-triggered DMA channel.
// Behaviour
// [RULE_01] Single address mode finishes in one cycle.
// [RULE_02] Dual address mode: read then write.
// [RULE_03] Channel always uses explicit source and destination.
// [RULE_04] No bus mode; runs beside other masters.
// [RULE_05] Module stop released after reset.
// [RULE_06] One stop bit gates DMA and DTC.
// [RULE_07] Source mode 00b keeps source fixed.
// [RULE_08] Destination mode 10b increments by unit.
// [RULE_09] Source type 01b starts on peripheral request.
// [RULE_10] Transfer mode 00b moves one unit per request.
// [RULE_11] Size 00b means one byte unit.
// [RULE_12] Clear select 0 clears trigger flag at start.
// [RULE_13] Count down; at end set flag, request interrupt.
// [RULE_14] Transfer enable clears the end flag.
// [RULE_15] End interrupt only while enable bit set.
// [RULE_16] Trigger select holds activating vector number.
// [RULE_17] Transfers need start bit and channel enable.
// [RULE_18] Software stops channel before changing settings.
// [RULE_19] Count zero means free running.
package dma_chan_pkg;

   // *************************************************************
   // Field encodings
   // *************************************************************
   localparam logic [1:0] ADDR_FIXED     = 2'h0;
   localparam logic [1:0] ADDR_INCREMENT = 2'h2;
   localparam logic [1:0] TRIG_PERIPHERAL = 2'h1;
   localparam logic [1:0] MODE_NORMAL    = 2'h0;
   localparam logic [1:0] SIZE_BYTE      = 2'h0;
   localparam logic       FLAG_CLEAR_AT_START = 1'h0;

   // *************************************************************
   // Reset values and widths
   // *************************************************************
   localparam logic       STOP_RESET     = 1'h0;
   localparam int         ADDR_W         = 32;
   localparam int         COUNT_W        = 16;
   localparam int         VECTOR_W       = 8;
   localparam logic [7:0] VECTOR_RESET   = 8'h00;
   localparam logic [15:0] COUNT_FREE    = 16'h0000;

   // Channel sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_WRITE = 2'b10
   } chan_state_t;

endpackage

// *** dma_channel_peripheral_trigger.sv ***
// One DMA channel started by a selected peripheral interrupt request.
module dma_channel_peripheral_trigger
   import dma_chan_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int CW = COUNT_W,
   parameter int VW = VECTOR_W
) (
   input  wire logic          core_clk_in,
   input  wire logic          rst_in,
   // Module control.
   input  wire logic          dma_dtc_stop_bit_in,
   input  wire logic          ext_dma_stop_bit_in,
   input  wire logic          module_start_bit_in,
   input  wire logic          channel_transfer_enable_in,
   // Channel settings.
   input  wire logic [1:0]    source_addr_mode_field_in,
   input  wire logic [1:0]    dest_addr_mode_field_in,
   input  wire logic [1:0]    activation_source_type_in,
   input  wire logic [1:0]    transfer_mode_field_in,
   input  wire logic [1:0]    transfer_size_field_in,
   input  wire logic          source_flag_clear_select_in,
   input  wire logic          transfer_end_irq_enable_in,
   input  wire logic [AW-1:0] source_address_in,
   input  wire logic [AW-1:0] dest_address_in,
   input  wire logic [CW-1:0] transfer_count_in,
   input  wire logic [VW-1:0] trigger_select_in,
   // Trigger from the interrupt controller.
   input  wire logic          periph_req_in,
   input  wire logic [VW-1:0] periph_vector_in,
   // Bus master.
   input  wire logic          bus_ready_in,
   input  wire logic [7:0]    bus_rdata_in,
   // Outputs.
   output logic               bus_req_out,
   output logic               bus_we_out,
   output logic [AW-1:0]      bus_addr_out,
   output logic [7:0]         bus_wdata_out,
   output logic               trigger_flag_clear_out,
   output logic               transfer_end_flag_out,
   output logic               channel0_end_interrupt_out,
   output logic [CW-1:0]      count_left_out,
   output logic               dma_clock_on_out,
   output logic               ext_dma_clock_on_out
);
   initial begin
      if (CW != 16) $error("count width must be 16");
   end

   // *************************************************************
   // Declarations
   // *************************************************************
   chan_state_t     state;
   chan_state_t     next_state;
   logic [AW-1:0]   src;
   logic [AW-1:0]   next_src;
   logic [AW-1:0]   dst;
   logic [AW-1:0]   next_dst;
   logic [CW-1:0]   cnt;
   logic [CW-1:0]   next_cnt;
   logic            loaded;
   logic            next_loaded;
   logic            pend;
   logic            next_pend;
   logic            run_d;
   logic            next_run_d;
   logic [7:0]      data;
   logic [7:0]      next_data;
   logic            end_flag;
   logic            next_end_flag;
   logic            irq;
   logic            next_irq;
   logic            fclr;
   logic            next_fclr;
   logic            breq;
   logic            next_breq;
   logic            bwe;
   logic            next_bwe;
   logic [AW-1:0]   baddr;
   logic [AW-1:0]   next_baddr;
   logic            clk_on;
   logic            next_clk_on;
   logic            xclk_on;
   logic            next_xclk_on;
   logic            run;
   logic            hit;
   logic [AW-1:0]   src_step;
   logic [AW-1:0]   dst_step;

   // *************************************************************
   // Helpers
   // *************************************************************
   // Source side: fixed unless incrementing is chosen.
   addr_step #(.AW(AW)) u_src_step (
      .addr_in  (src),
      .mode_in  (source_addr_mode_field_in),
      .size_in  (transfer_size_field_in),
      .addr_out (src_step)
   );

   addr_step #(.AW(AW)) u_dst_step (
      .addr_in  (dst),
      .mode_in  (dest_addr_mode_field_in),
      .size_in  (transfer_size_field_in),
      .addr_out (dst_step)
   );

   trig_match #(.VW(VW)) u_trig (
      .sel_vector_in (trigger_select_in),
      .req_vector_in (periph_vector_in),
      .req_valid_in  (periph_req_in),
      .hit_out       (hit)
   );

   // The channel runs only with its clock on and both enables set.
   assign run = clk_on && module_start_bit_in && channel_transfer_enable_in; // RULE_17 RULE_06

   // *************************************************************
   // Next-state logic
   // *************************************************************
   // Each request is a read cycle then a write cycle; the bus request is held through both
   // cycles of one request, so other masters on other slaves proceed between requests.
   always_comb begin
      next_state    = state;
      next_src      = src;
      next_dst      = dst;
      next_cnt      = cnt;
      next_loaded   = loaded;
      next_pend     = pend;
      next_run_d    = run;
      next_data     = data;
      next_end_flag = end_flag;
      next_irq      = 1'b0;
      next_fclr     = 1'b0;
      next_breq     = breq;
      next_bwe      = bwe;
      next_baddr    = baddr;
      // Stop bits low mean clock supplied; one bit serves DMA and DTC together.
      next_clk_on   = !dma_dtc_stop_bit_in; // RULE_06 RULE_05
      // The external-request controller and its one-cycle single address mode live outside this channel.
      // Only its own stop bit passes through here, so it can be stopped apart from this one.
      next_xclk_on  = !ext_dma_stop_bit_in; // RULE_06 RULE_01
      // Rising run clears the end flag, and reloads the settings only when none are still loaded.
      if (run && !run_d) begin
         next_end_flag = 1'b0; // RULE_14
         if (!loaded) begin
            next_src    = source_address_in;
            next_dst    = dest_address_in;
            next_cnt    = transfer_count_in;
            next_loaded = 1'b1;
         end
      end
      if (!channel_transfer_enable_in) begin
         next_loaded = 1'b0;
      end
      case (state)
         ST_IDLE: begin
            if (run && loaded && run_d && pend) begin
               next_pend  = 1'b0;
               next_fclr  = (source_flag_clear_select_in == FLAG_CLEAR_AT_START); // RULE_12
               next_breq  = 1'b1; // RULE_02 RULE_03 RULE_04
               next_bwe   = 1'b0;
               next_baddr = src;
               next_state = ST_READ;
            end
         end
         ST_READ: begin
            if (bus_ready_in) begin
               next_data  = bus_rdata_in; // RULE_11
               next_bwe   = 1'b1;
               next_baddr = dst;
               next_state = ST_WRITE; // RULE_02
            end
         end
         ST_WRITE: begin
            if (bus_ready_in) begin
               next_breq  = 1'b0;
               next_bwe   = 1'b0;
               next_src   = src_step; // RULE_07
               next_dst   = dst_step; // RULE_08
               next_state = ST_IDLE;
               // Zero count runs free; otherwise count down to the end.
               if (cnt != COUNT_FREE) begin // RULE_19
                  next_cnt = cnt - CW'(1); // RULE_13
                  if (cnt == CW'(1)) begin
                     next_end_flag = 1'b1; // RULE_13
                     next_irq      = transfer_end_irq_enable_in; // RULE_15
                     next_loaded   = 1'b0;
                  end
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // Only peripheral requests in normal mode start the channel.
      // This sits after the case so that a trigger landing on the edge that consumes
      // the pending one is kept and not swallowed by the consume.
      if (hit && activation_source_type_in == TRIG_PERIPHERAL
          && transfer_mode_field_in == MODE_NORMAL) begin // RULE_09 RULE_10
         next_pend = 1'b1;
      end
   end

   // *************************************************************
   // State registers
   // *************************************************************
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state    <= ST_IDLE;
         src      <= '0;
         dst      <= '0;
         cnt      <= '0;
         loaded   <= 1'b0;
         pend     <= 1'b0;
         run_d    <= 1'b0;
         data     <= 8'h00;
         end_flag <= 1'b0;
         irq      <= 1'b0;
         fclr     <= 1'b0;
         breq     <= 1'b0;
         bwe      <= 1'b0;
         baddr    <= '0;
         clk_on   <= !STOP_RESET; // RULE_05
         xclk_on  <= !STOP_RESET;
      end else begin
         state    <= next_state;
         src      <= next_src;
         dst      <= next_dst;
         cnt      <= next_cnt;
         loaded   <= next_loaded;
         pend     <= next_pend;
         run_d    <= next_run_d;
         data     <= next_data;
         end_flag <= next_end_flag;
         irq      <= next_irq;
         fclr     <= next_fclr;
         breq     <= next_breq;
         bwe      <= next_bwe;
         baddr    <= next_baddr;
         clk_on   <= next_clk_on;
         xclk_on  <= next_xclk_on;
      end
   end

   // Outputs straight from flip-flops.
   assign bus_req_out                = breq;
   assign bus_we_out                 = bwe;
   assign bus_addr_out               = baddr;
   assign bus_wdata_out              = data;
   assign trigger_flag_clear_out     = fclr;
   assign transfer_end_flag_out      = end_flag;
   assign channel0_end_interrupt_out = irq;
   assign count_left_out             = cnt;
   assign dma_clock_on_out           = clk_on;
   assign ext_dma_clock_on_out       = xclk_on;

   // *************************************************************
   // Assertions
   // *************************************************************
   AST_READ_THEN_WRITE: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_02
      (state == ST_READ && bus_ready_in) |=> (state == ST_WRITE && bus_we_out && bus_addr_out == $past(dst)))
      else $error("write did not follow read");
   AST_FIXED_SRC: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_07
      (state == ST_WRITE && bus_ready_in && source_addr_mode_field_in == ADDR_FIXED) |=> src == $past(src))
      else $error("fixed source moved");
   AST_INC_DST: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_08
      (state == ST_WRITE && bus_ready_in && dest_addr_mode_field_in == ADDR_INCREMENT) |=> dst == $past(dst) + 1)
      else $error("destination not incremented");
   AST_END_IRQ: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_15
      channel0_end_interrupt_out |-> transfer_end_flag_out && $past(transfer_end_irq_enable_in))
      else $error("end interrupt without enable");
   AST_END_COUNT: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_13
      (state == ST_WRITE && bus_ready_in && cnt == 16'h0001) |=> transfer_end_flag_out && cnt == 16'h0000)
      else $error("end flag missing at count end");
   AST_FREE_RUN: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_19
      (state == ST_WRITE && bus_ready_in && cnt == 16'h0000) |=> cnt == 16'h0000 && !channel0_end_interrupt_out)
      else $error("free running count changed");
   AST_FLAG_CLEAR: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_12
      (state == ST_IDLE && next_state == ST_READ && source_flag_clear_select_in == 1'b0) |=> trigger_flag_clear_out)
      else $error("trigger flag not cleared");
   AST_RUN_GATE: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_17
      (state == ST_IDLE && !run) |=> state == ST_IDLE)
      else $error("transfer started while stopped");
   AST_END_CLEARED: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_14
      (run && !run_d) |=> !transfer_end_flag_out)
      else $error("end flag not cleared on enable");
   // Request hold, stop bits and trigger gating.
   AST_REQ_HELD: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_02
      (bus_req_out && !bus_ready_in) |=> bus_req_out && $stable(bus_we_out) && $stable(bus_addr_out))
      else $error("bus cycle changed before ready");
   AST_DMA_STOP: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_06
      dma_dtc_stop_bit_in |=> !dma_clock_on_out)
      else $error("shared stop bit did not stop the clock");
   AST_EXT_STOP: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_06
      ext_dma_stop_bit_in |=> !ext_dma_clock_on_out)
      else $error("external stop bit did not stop its clock");
   AST_TYPE_GATE: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_09
      (!pend && activation_source_type_in != TRIG_PERIPHERAL) |=> !pend)
      else $error("request taken with wrong source type");
   AST_MODE_GATE: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_10
      (!pend && transfer_mode_field_in != MODE_NORMAL) |=> !pend)
      else $error("request taken outside normal mode");
endmodule

// *** tb.sv ***
// Self-checking testbench for the peripheral-triggered DMA channel.
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
   $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module tb import dma_chan_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************************************
   // Signals and instances
   // ***************************************************************
   localparam logic [31:0] SRC = 32'h0008_A014;
   localparam logic [31:0] DST = 32'h0000_1000;
   logic clk, rst, dstop, xstop, start, en, clr_sel, ie, preq, ready, req, we, fclr, eflag, irq, dck, xck;
   logic [1:0] smd, dmd, typ, md;
   logic [31:0] addr;
   logic [15:0] cnt, left;
   logic [7:0] vec, rdata, wdata, rd_num;
   logic [3:0] wt;
   int err_total, checked, clr_cnt, irq_cnt;

   dma_channel_peripheral_trigger dut (
      .core_clk_in(clk), .rst_in(rst), .dma_dtc_stop_bit_in(dstop), .ext_dma_stop_bit_in(xstop),
      .module_start_bit_in(start), .channel_transfer_enable_in(en), .source_addr_mode_field_in(smd),
      .dest_addr_mode_field_in(dmd), .activation_source_type_in(typ), .transfer_mode_field_in(md),
      .transfer_size_field_in(SIZE_BYTE), .source_flag_clear_select_in(clr_sel),
      .transfer_end_irq_enable_in(ie), .source_address_in(SRC), .dest_address_in(DST),
      .transfer_count_in(cnt), .trigger_select_in(8'd100), .periph_req_in(preq), .periph_vector_in(vec),
      .bus_ready_in(ready), .bus_rdata_in(rdata), .bus_req_out(req), .bus_we_out(we), .bus_addr_out(addr),
      .bus_wdata_out(wdata), .trigger_flag_clear_out(fclr), .transfer_end_flag_out(eflag),
      .channel0_end_interrupt_out(irq), .count_left_out(left), .dma_clock_on_out(dck),
      .ext_dma_clock_on_out(xck));

   dma_bus_slave slave (.clk_in(clk), .rst_in(rst), .wait_in(wt), .bus_req_in(req), .bus_we_in(we),
      .bus_ready_out(ready), .bus_rdata_out(rdata));

   // Pulses last one cycle, so they are counted at every edge.
   always @(posedge clk) begin
      clr_cnt += fclr;
      irq_cnt += irq;
   end

   // ***************************************************************
   // Shared tasks
   // ***************************************************************
   task automatic test_done();
      $display("checks %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Settings change only while the channel is stopped.
   task automatic setup(input logic [1:0] s, d, t, m, input logic irq_en, input logic [15:0] n);
      @(negedge clk);
      start = 1'b0; en = 1'b0;
      smd = s; dmd = d; typ = t; md = m; ie = irq_en; cnt = n;
      @(negedge clk);
      start = 1'b1; en = 1'b1;
      repeat (2) @(negedge clk);
   endtask

   task automatic request(input logic [7:0] v);
      @(negedge clk);
      preq = 1'b1; vec = v;
      @(negedge clk);
      preq = 1'b0;
   endtask

   // Follows one read-then-write transfer; a transfer that never finishes ends the run.
   task automatic xfer(input logic [31:0] s, d);
      bit rd_ok;
      rd_ok = 0;
      for (int n = 0; n < 60; n++) begin
         @(negedge clk);
         if (req && ready && !we) begin
            `CHK(addr, s)
            rd_ok = 1;
         end else if (req && ready && we) begin
            `CHK(rd_ok, 1'b1)
            `CHK(addr, d)
            `CHK(wdata, 8'h40 + rd_num)
            rd_num++;
            return;
         end
      end
      err_total++;
      $display("mismatch at %0t: transfer never finished", $time);
      test_done();
   endtask

   task automatic quiet(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) @(negedge clk) seen |= req;
      `CHK(seen, 1'b0)
   endtask

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic t_reset_stop();
      `CHK({dck, xck, eflag, req, irq}, 5'b11000)
      @(negedge clk) dstop = 1'b1;
      repeat (2) @(negedge clk);
      `CHK({dck, xck}, 2'b01)
      dstop = 1'b0; xstop = 1'b1;
      repeat (2) @(negedge clk);
      `CHK({dck, xck}, 2'b10)
      xstop = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   // Thirty-two byte transfers, half with a slow slave, ending in one end interrupt.
   task automatic t_main();
      int c0, i0;
      c0 = clr_cnt; i0 = irq_cnt;
      setup(ADDR_FIXED, ADDR_INCREMENT, TRIG_PERIPHERAL, MODE_NORMAL, 1'b1, 16'd32);
      `CHK(eflag, 1'b0)
      for (int i = 0; i < 32; i++) begin
         wt = (i < 16) ? 4'h0 : 4'h3;
         request(8'd100);
         xfer(SRC, DST + i);
         @(negedge clk);
         `CHK(left, 16'(31 - i))
         `CHK(eflag, (i == 31))
      end
      repeat (2) @(negedge clk);
      `CHK(clr_cnt - c0, 32)
      `CHK(irq_cnt - i0, 1)
   endtask

   // Wrong vector, halted module, wrong source type and wrong mode all refuse to move data.
   task automatic t_refuse();
      setup(ADDR_FIXED, ADDR_INCREMENT, TRIG_PERIPHERAL, MODE_NORMAL, 1'b1, 16'd4);
      request(8'd99);
      quiet(20);
      @(negedge clk) start = 1'b0;
      request(8'd100);
      quiet(10);
      start = 1'b1;
      xfer(SRC, DST);
      setup(ADDR_FIXED, ADDR_INCREMENT, 2'h0, MODE_NORMAL, 1'b1, 16'd4);
      request(8'd100);
      quiet(20);
      setup(ADDR_FIXED, ADDR_INCREMENT, TRIG_PERIPHERAL, 2'h1, 1'b1, 16'd4);
      request(8'd100);
      quiet(20);
   endtask

   task automatic t_noirq_free();
      int i0;
      i0 = irq_cnt;
      setup(ADDR_FIXED, ADDR_INCREMENT, TRIG_PERIPHERAL, MODE_NORMAL, 1'b0, 16'd1);
      request(8'd100);
      xfer(SRC, DST);
      repeat (3) @(negedge clk);
      `CHK(eflag, 1'b1)
      `CHK(irq_cnt - i0, 0)
      // Source now steps and destination stays, the mirror of the main scenario.
      setup(ADDR_INCREMENT, ADDR_FIXED, TRIG_PERIPHERAL, MODE_NORMAL, 1'b1, COUNT_FREE);
      `CHK(eflag, 1'b0)
      for (int i = 0; i < 3; i++) begin
         request(8'd100);
         xfer(SRC + i, DST);
      end
      repeat (3) @(negedge clk);
      `CHK(eflag, 1'b0)
      `CHK(irq_cnt - i0, 0)
   endtask

   // ***************************************************************
   // Clock, reset and main sequence
   // ***************************************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      err_total = 0; checked = 0; clr_cnt = 0; irq_cnt = 0; rd_num = 8'h00;
      rst = 1'b1; dstop = 1'b0; xstop = 1'b0; start = 1'b0; en = 1'b0; clr_sel = FLAG_CLEAR_AT_START;
      dmd = ADDR_INCREMENT; typ = TRIG_PERIPHERAL; md = MODE_NORMAL; ie = 1'b0; cnt = 16'h0000;
      preq = 1'b0; vec = 8'h00; wt = 4'h0; smd = ADDR_FIXED;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_reset_stop();
      t_main();
      t_refuse();
      t_noirq_free();
      test_done();
   end
endmodule

// *** trig_match.sv ***
// Trigger selector: passes the request whose vector matches the selected one.
module trig_match
   import dma_chan_pkg::*;
#(
   parameter int VW = VECTOR_W
) (
   input  wire logic [VW-1:0] sel_vector_in,
   input  wire logic [VW-1:0] req_vector_in,
   input  wire logic          req_valid_in,
   output logic               hit_out
);
   initial begin
      if (VW < 7) $error("trig_match: vector width must reach 100");
   end

   // The channel answers only to the programmed vector number.
   always_comb begin
      hit_out = req_valid_in && (req_vector_in == sel_vector_in); // RULE_16
   end
endmodule
